// >>> design/adcr_regs.vh
`ifndef ADCR_REGS_VH
`define ADCR_REGS_VH
// register indexes; the byte address is four times the index
`define ADCR_IDX_IEC 8'h16
`define ADCR_IDX_IES 8'h17
`define ADCR_IDX_FLG 8'h18
`define ADCR_IDX_STA 8'h19
`define ADCR_IDX_RES 8'h1A
`define ADCR_IDX_WLO 8'h1C
`define ADCR_IDX_WHI 8'h20
`define ADCR_IDX_GAIN 8'h24
`define ADCR_IDX_OFS 8'h26
`define ADCR_IDX_CTL 8'h30
// flag and enable bit positions
`define ADCR_B_RESULT_READY 0
`define ADCR_B_OVR 1
`define ADCR_B_WIN 2
`define ADCR_B_SYNC 3
`define ADCR_B_BUSY 7
// control bits
`define ADCR_C_CORR 0
`define ADCR_C_LJ 1
`define ADCR_C_OVS 2
`define ADCR_C_WM_HI 6
`define ADCR_C_WM_LO 4
// window modes
`define ADCR_WM_OFF 3'h0
`define ADCR_WM_ABOVE 3'h1
`define ADCR_WM_BELOW 3'h2
`define ADCR_WM_INSIDE 3'h3
`define ADCR_WM_OUTSIDE 3'h4
// reset values
`define ADCR_RST8 8'h00
`define ADCR_RST16 16'h0000
// cycles a register hand-over to the converter side takes
`define ADCR_SYNC_CYCLES 4'h3
`endif

// >>> design/adcr_sync.v
`timescale 1ns/1ps
`default_nettype none
`include "adcr_regs.vh"
module adcr_sync (
    input wire ref_clk,
    input wire reset,
    input wire start,
    input wire quiet,
    output wire busy,
    output wire done,
    output wire ready_evt
);
    reg [3:0] cnt_q;
    reg busy_q;
    reg quiet_q;

    ////////////////////////////////////////////////////////////////////
    // a new start restarts the count, so the last write always lands
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cnt_q <= 4'h0;
            busy_q <= 1'b0;
            quiet_q <= 1'b0;
        end else if (start | quiet) begin
            cnt_q <= `ADCR_SYNC_CYCLES;
            busy_q <= 1'b1;
            quiet_q <= quiet;
        end else if (busy_q) begin
            cnt_q <= cnt_q - 4'h1;
            if (cnt_q == 4'h1) begin
                busy_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // the fall of busy; enable or soft reset falls stay silent
    assign busy = busy_q;
    assign done = busy_q & (cnt_q == 4'h1) & ~start & ~quiet;
    assign ready_evt = done & ~quiet_q;
endmodule
`default_nettype wire

// >>> design/adcr_corr.v
`timescale 1ns/1ps
`default_nettype none
module adcr_corr (
    input wire [15:0] raw,
    input wire [11:0] gain,
    input wire [11:0] offset,
    input wire corr_en,
    input wire left_j,
    input wire ovs,
    output reg [15:0] value
);
    wire signed [17:0] diff;
    wire signed [30:0] prod;
    wire signed [19:0] scl;
    wire [15:0] lim;
    reg [15:0] sat;
    reg [15:0] pick;

    ////////////////////////////////////////////////////////////////////
    // offset is two's complement; gain is 1.11 fixed point
    assign diff = $signed({2'b00, raw})
        - $signed({{6{offset[11]}}, offset});
    assign prod = diff * $signed({1'b0, gain});
    assign scl = prod[30:11];
    assign lim = ovs ? 16'hFFFF : 16'h0FFF;

    // saturate so a corrected value never wraps around
    always @* begin
        if (scl < 0) begin
            sat = 16'h0000;
        end else if (scl > $signed({4'h0, lim})) begin
            sat = lim;
        end else begin
            sat = scl[15:0];
        end
        pick = corr_en ? sat : raw;
        if (ovs) begin
            value = pick;
        end else if (left_j) begin
            value = {pick[11:0], 4'h0};
        end else begin
            value = {4'h0, pick[11:0]};
        end
    end
endmodule
`default_nettype wire

// >>> design/adcr_top.v
// Contract
// - a one to set-register bit 3 turns on the sync-ready enable
// - a one to set-register bit 2 turns on window enable; reads show it
// - a one to set-register bit 1 turns on overrun enable; zero leaves it
// - a one to set-register bit 0 turns on result enable; zero leaves it
// - a one written to a flag bit clears it; zero does nothing
// - sync-ready flag sets when sync busy falls, unless enable or reset
// - request is raised when any flag and its enable are both one
// - window flag sets two cycles after a result meets the window test
// - reading the result clears window and result-ready flags
// - overrun flag sets when a result lands before the last was read
// - result-ready flag sets when a new result is stored
// - status bit 7 is high while a register hand-over is in progress
// - result register is read only and sixteen bits wide
// - a plain conversion gives twelve bits, placed by left justify
// - left justified result sits in bits 15:4
// - right justified, no oversampling, result sits in bits 11:0
// - with oversampling the full sixteen bits are kept
// - sixteen-bit lower bound, reset zero, feeds the window test
// - sixteen-bit upper bound, reset zero, feeds the window test
// - with correction on, the value is gain corrected before storing
// - gain is one integer bit and eleven fraction bits
// - bound writes pass through hand-over and obey write protection
// - a one to clear-register bit clears that enable and its request
// - with correction on, a signed offset is applied before storing
`timescale 1ns/1ps
`default_nettype none
`include "adcr_regs.vh"
module adcr_top (
    input wire ref_clk,
    input wire reset,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [9:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output wire wb_ack_o,
    input wire conv_done,
    input wire [15:0] conv_value,
    input wire quiet_sync_start,
    input wire write_protect,
    output wire irq_req,
    output wire window_match,
    output wire correction_enable,
    output wire left_justify,
    output wire sync_busy_a
);
    reg ack_q;
    reg [3:0] ien_q;
    reg [3:0] flag_q;
    reg [15:0] res_q;
    reg unread_q;
    reg [15:0] wlo_q;
    reg [15:0] whi_q;
    reg [15:0] wlo_core_q;
    reg [15:0] whi_core_q;
    reg [11:0] gain_q;
    reg [11:0] ofs_q;
    reg [7:0] ctl_q;
    reg win_hit_q;
    reg [3:0] flag_d;
    reg [31:0] rdata;
    reg in_win;
    wire req;
    wire wr;
    wire rd;
    wire [7:0] idx;
    wire wr_ok;
    wire res_rd;
    wire bound_wr;
    wire sync_done;
    wire sync_evt;
    wire [15:0] corr_val;
    wire [2:0] wmode;
    wire [15:0] gain_mrg;
    wire [15:0] ofs_mrg;

    ////////////////////////////////////////////////////////////////////
    // bus decode helpers

    // true when the access targets the given index
    function hit;
        input [7:0] a;
        input [7:0] b;
        begin
            hit = (a == b);
        end
    endfunction

    // merge the two low byte lanes into a sixteen-bit register
    function [15:0] lanes16;
        input [15:0] old;
        input [31:0] dat;
        input [3:0] sel;
        begin
            lanes16 = old;
            if (sel[0]) begin
                lanes16[7:0] = dat[7:0];
            end
            if (sel[1]) begin
                lanes16[15:8] = dat[15:8];
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // wishbone slave: one wait state, ack drops the cycle after it rose

    // ack_q masks the request so one access has exactly one effect
    assign req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr = req & wb_we_i;
    assign rd = req & ~wb_we_i;
    assign idx = wb_adr_i[9:2];
    assign wb_ack_o = ack_q;

    // protected writes are acked but dropped, flags stay writable
    assign wr_ok = wr & ~write_protect & wb_sel_i[0];
    assign res_rd = rd & hit(idx, `ADCR_IDX_RES);
    assign bound_wr = wr & ~write_protect & (wb_sel_i[1:0] != 2'b00)
        & (hit(idx, `ADCR_IDX_WLO) | hit(idx, `ADCR_IDX_WHI));

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupt enables: set and clear registers share one store

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ien_q <= 4'h0;
        end else if (wr_ok & hit(idx, `ADCR_IDX_IES)) begin
            // zeros leave the enables alone
            ien_q <= ien_q | wb_dat_i[3:0];
        end else if (wr_ok & hit(idx, `ADCR_IDX_IEC)) begin
            ien_q <= ien_q & ~wb_dat_i[3:0];
        end
    end

    // a cleared enable withdraws its request at once
    assign irq_req = |(flag_q & ien_q);

    ////////////////////////////////////////////////////////////////////
    // control: correction, justification, oversampling, window mode

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ctl_q <= `ADCR_RST8;
        end else if (wr_ok & hit(idx, `ADCR_IDX_CTL)) begin
            ctl_q <= wb_dat_i[7:0];
        end
    end

    assign correction_enable = ctl_q[`ADCR_C_CORR];
    assign left_justify = ctl_q[`ADCR_C_LJ];
    assign wmode = ctl_q[`ADCR_C_WM_HI:`ADCR_C_WM_LO];

    ////////////////////////////////////////////////////////////////////
    // correction values, both protected but not hand-over delayed

    // merged words; only the low twelve bits are kept, upper lanes drop
    assign gain_mrg = lanes16({4'h0, gain_q}, wb_dat_i, wb_sel_i);
    assign ofs_mrg = lanes16({4'h0, ofs_q}, wb_dat_i, wb_sel_i);

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            gain_q <= 12'h000;
            ofs_q <= 12'h000;
        end else if (wr & ~write_protect) begin
            if (hit(idx, `ADCR_IDX_GAIN)) begin
                gain_q <= gain_mrg[11:0];
            end
            if (hit(idx, `ADCR_IDX_OFS)) begin
                ofs_q <= ofs_mrg[11:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // window bounds: software copy plus converter-side copy

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wlo_q <= `ADCR_RST16;
            whi_q <= `ADCR_RST16;
        end else if (bound_wr) begin
            if (hit(idx, `ADCR_IDX_WLO)) begin
                wlo_q <= lanes16(wlo_q, wb_dat_i, wb_sel_i);
            end else begin
                whi_q <= lanes16(whi_q, wb_dat_i, wb_sel_i);
            end
        end
    end

    // the comparator only sees a bound once the hand-over finishes,
    // so a half-written pair never reaches it mid-conversion
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wlo_core_q <= `ADCR_RST16;
            whi_core_q <= `ADCR_RST16;
        end else if (sync_done) begin
            wlo_core_q <= wlo_q;
            whi_core_q <= whi_q;
        end
    end

    adcr_sync u_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .start(bound_wr),
        .quiet(quiet_sync_start),
        .busy(sync_busy_a),
        .done(sync_done),
        .ready_evt(sync_evt)
    );

    ////////////////////////////////////////////////////////////////////
    // result path: correct and justify, then store on the strobe

    adcr_corr u_corr (
        .raw(conv_value),
        .gain(gain_q),
        .offset(ofs_q),
        .corr_en(ctl_q[`ADCR_C_CORR]),
        .left_j(ctl_q[`ADCR_C_LJ]),
        .ovs(ctl_q[`ADCR_C_OVS]),
        .value(corr_val)
    );

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            res_q <= `ADCR_RST16;
            unread_q <= 1'b0;
        end else if (conv_done) begin
            res_q <= corr_val;
            unread_q <= 1'b1;
        end else if (res_rd) begin
            unread_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // window test on the stored value, pulsed one cycle later, flagged the cycle after

    always @* begin
        case (wmode)
            `ADCR_WM_ABOVE: in_win = (res_q > wlo_core_q);
            `ADCR_WM_BELOW: in_win = (res_q < whi_core_q);
            `ADCR_WM_INSIDE: in_win = (res_q > wlo_core_q)
                & (res_q < whi_core_q);
            `ADCR_WM_OUTSIDE: in_win = (res_q < wlo_core_q)
                | (res_q > whi_core_q);
            default: in_win = 1'b0;
        endcase
    end

    // the strobe is delayed so the test sees the freshly stored value
    reg load_q;
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            load_q <= 1'b0;
            win_hit_q <= 1'b0;
        end else begin
            load_q <= conv_done;
            win_hit_q <= load_q & in_win;
        end
    end

    assign window_match = win_hit_q;

    ////////////////////////////////////////////////////////////////////
    // flags: clears first, then sets, so an event is never lost

    always @* begin
        flag_d = flag_q;
        if (wr & wb_sel_i[0] & hit(idx, `ADCR_IDX_FLG)) begin
            flag_d = flag_d & ~wb_dat_i[3:0];
        end
        if (res_rd) begin
            flag_d[`ADCR_B_RESULT_READY] = 1'b0;
            flag_d[`ADCR_B_WIN] = 1'b0;
        end
        if (conv_done) begin
            flag_d[`ADCR_B_RESULT_READY] = 1'b1;
        end
        if (conv_done & unread_q & ~res_rd) begin
            flag_d[`ADCR_B_OVR] = 1'b1;
        end
        if (win_hit_q) begin
            flag_d[`ADCR_B_WIN] = 1'b1;
        end
        if (sync_evt) begin
            flag_d[`ADCR_B_SYNC] = 1'b1;
        end
    end

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            flag_q <= 4'h0;
        end else begin
            flag_q <= flag_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read mux; unmapped indexes read zero but are still acked

    always @* begin
        rdata = 32'h00000000;
        case (idx)
            `ADCR_IDX_IES: rdata[3:0] = ien_q;
            `ADCR_IDX_IEC: rdata[3:0] = ien_q;
            `ADCR_IDX_FLG: rdata[3:0] = flag_q;
            `ADCR_IDX_STA: rdata[`ADCR_B_BUSY] = sync_busy_a;
            `ADCR_IDX_RES: rdata[15:0] = res_q;
            `ADCR_IDX_WLO: rdata[15:0] = wlo_q;
            `ADCR_IDX_WHI: rdata[15:0] = whi_q;
            `ADCR_IDX_GAIN: rdata[11:0] = gain_q;
            `ADCR_IDX_OFS: rdata[11:0] = ofs_q;
            `ADCR_IDX_CTL: rdata[7:0] = ctl_q;
            default: rdata = 32'h00000000;
        endcase
    end

    // read data is registered together with ack
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wb_dat_o <= 32'h00000000;
        end else if (rd) begin
            wb_dat_o <= rdata;
        end
    end
endmodule
`default_nettype wire

// >>> sim/adcr_checker.sv
`timescale 1ns/1ps
`default_nettype none
// port-level watcher for the result and interrupt register block
module adcr_checker (
    input wire ref_clk,
    input wire reset,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [9:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire conv_done,
    input wire [15:0] conv_value,
    input wire quiet_sync_start,
    input wire write_protect,
    input wire irq_req,
    input wire window_match,
    input wire correction_enable,
    input wire left_justify,
    input wire sync_busy_a
);
    // one clock domain, so clocking and reset are given once
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    // bus request and write request seen at the block's pins
    wire req_w = wb_cyc_i && wb_stb_i;
    wire wr_w = req_w && wb_we_i;

    // the bus answers one cycle after taking a request, for one cycle
    a_ack_next: assert property (req_w && !wb_ack_o |=> wb_ack_o)
        else $error("no ack after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    // read data only moves when a read is answered
    a_dat_hold: assert property (
        $changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
        else $error("read data changed outside a read answer");
    // a request only rises from a flag or enable source one cycle back;
    // the sync flag lands in the same cycle that busy drops
    a_irq_rise: assert property ($rose(irq_req) |->
        $past(conv_done) || $past(window_match) || $past(wr_w) ||
        $past(sync_busy_a) || $past(sync_busy_a, 2))
        else $error("request rose with no cause");
    a_irq_fall: assert property ($fell(irq_req) |-> $past(req_w))
        else $error("request dropped without a bus access");
    // window pulse comes two cycles after the done strobe
    a_win_cause: assert property (
        window_match |-> $past(conv_done, 2))
        else $error("window pulse without a conversion");
    // hand-over lasts at least three cycles and starts from a cause
    a_busy_min: assert property (
        $rose(sync_busy_a) |-> sync_busy_a[*3])
        else $error("hand-over shorter than three cycles");
    a_busy_cause: assert property ($rose(sync_busy_a) |->
        $past(wr_w) || $past(quiet_sync_start))
        else $error("hand-over started with no write");
    a_busy_fall: assert property (
        $fell(sync_busy_a) |-> $past(sync_busy_a, 3))
        else $error("hand-over ended early");
    // control outputs move only on an unprotected write
    a_ctl_write: assert property (
        $changed({correction_enable, left_justify}) |->
        $past(wr_w && !write_protect))
        else $error("control changed without a write");
endmodule
///////////////////////////////////////////////////////////////////////////////
bind adcr_top adcr_checker adcr_checker_i (
    .ref_clk(ref_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .conv_done(conv_done), .conv_value(conv_value),
    .quiet_sync_start(quiet_sync_start), .write_protect(write_protect),
    .irq_req(irq_req), .window_match(window_match),
    .correction_enable(correction_enable), .left_justify(left_justify),
    .sync_busy_a(sync_busy_a)
);
`default_nettype wire

// >>> sim/adc_result_irq_window_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcr_regs.vh"
module adc_result_irq_window_regs_bench;
    logic ref_clk, reset, cyc, stb, we, conv_done, quiet, wp, win_seen;
    logic [3:0] sel;
    logic [9:0] adr;
    logic [31:0] wdat, r;
    logic [15:0] cval;
    wire [31:0] rdat;
    wire ack, irq, win, corr_en, lj, busy;
    int bad_count, comparisons, cycles;
    logic [7:0] idx [8] = '{`ADCR_IDX_IES, `ADCR_IDX_FLG, `ADCR_IDX_STA,
        `ADCR_IDX_RES, `ADCR_IDX_WLO, `ADCR_IDX_WHI, `ADCR_IDX_GAIN, 8'h3F};
    logic [4:0] hit0 = 5'h0E;
    logic [4:0] hit1 = 5'h12;

    adcr_top adcr_top_i (
        .ref_clk(ref_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .conv_done(conv_done),
        .conv_value(cval), .quiet_sync_start(quiet), .write_protect(wp),
        .irq_req(irq), .window_match(win), .correction_enable(corr_en),
        .left_justify(lj), .sync_busy_a(busy)
    );

    // 200 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // a hung wait ends the run as a failure
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    ///////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH t=%0t got %h want %h", $time, g, e);
        end
    endtask

    // single classic cycle; the request stays put until ack is sampled
    task automatic xfer(input logic w, input logic [7:0] ix,
                        input logic [15:0] d);
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'h3;
        adr <= {ix, 2'h0};
        wdat <= {16'h0000, d};
        @(posedge ref_clk);
        while (ack !== 1'b1) @(posedge ref_clk);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] ix, input logic [15:0] d);
        xfer(1'b1, ix, d);
    endtask

    task automatic rc(input logic [7:0] ix, input logic [31:0] e);
        xfer(1'b0, ix, 16'h0000);
        chk(r, e);
    endtask

    // one-cycle done strobe, then room for the window flag to land
    task automatic conv(input logic [15:0] v);
        @(posedge ref_clk);
        conv_done <= 1'b1;
        cval <= v;
        @(posedge ref_clk);
        conv_done <= 1'b0;
        // the window pulse stands in the second cycle after the strobe
        repeat (2) @(posedge ref_clk);
        win_seen = win;
        repeat (2) @(posedge ref_clk);
    endtask
    ///////////////////////////////////////////////////////////////////////////
    initial begin
        reset = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        sel = 4'h0;
        adr = 10'h000;
        wdat = 32'h0;
        conv_done = 1'b0;
        cval = 16'h0000;
        quiet = 1'b0;
        wp = 1'b0;
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        // reset values; the result read also marks it as taken
        foreach (idx[i]) rc(idx[i], 32'h0);
        $display("test reset values done");
        wr(`ADCR_IDX_IES, 16'h0005);
        rc(`ADCR_IDX_IES, 32'h5);
        wr(`ADCR_IDX_IES, 16'h000A);
        rc(`ADCR_IDX_IES, 32'hF);
        wr(`ADCR_IDX_IEC, 16'h0009);
        rc(`ADCR_IDX_IES, 32'h6);
        wr(`ADCR_IDX_IEC, 16'h0006);
        rc(`ADCR_IDX_IEC, 32'h0);
        $display("test enables done");
        conv(16'h0ABC);
        rc(`ADCR_IDX_FLG, 32'h1);
        chk(irq, 1'b0);
        wr(`ADCR_IDX_IES, 16'h0001);
        chk(irq, 1'b1);
        conv(16'h0123);
        rc(`ADCR_IDX_FLG, 32'h3);
        wr(`ADCR_IDX_FLG, 16'h0000);
        rc(`ADCR_IDX_RES, 32'h0123);
        rc(`ADCR_IDX_FLG, 32'h2);
        chk(irq, 1'b0);
        wr(`ADCR_IDX_FLG, 16'h0002);
        rc(`ADCR_IDX_FLG, 32'h0);
        wr(`ADCR_IDX_IEC, 16'h0001);
        $display("test flags done");
        wr(`ADCR_IDX_CTL, 16'h0002);
        chk(lj, 1'b1);
        conv(16'h0ABC);
        rc(`ADCR_IDX_RES, 32'hABC0);
        wr(`ADCR_IDX_CTL, 16'h0004);
        conv(16'hFEDC);
        rc(`ADCR_IDX_RES, 32'hFEDC);
        $display("test placement done");
        wr(`ADCR_IDX_GAIN, 16'h0400);
        rc(`ADCR_IDX_GAIN, 32'h400);
        wr(`ADCR_IDX_CTL, 16'h0001);
        chk(corr_en, 1'b1);
        conv(16'h0800);
        rc(`ADCR_IDX_RES, 32'h400);
        wr(`ADCR_IDX_GAIN, 16'h0800);
        wr(`ADCR_IDX_OFS, 16'h0010);
        conv(16'h0100);
        rc(`ADCR_IDX_RES, 32'hF0);
        wr(`ADCR_IDX_CTL, 16'h0000);
        $display("test correction done");
        wr(`ADCR_IDX_FLG, 16'h000F);
        wr(`ADCR_IDX_WLO, 16'h0100);
        chk(busy, 1'b1);
        repeat (6) @(posedge ref_clk);
        chk(busy, 1'b0);
        rc(`ADCR_IDX_FLG, 32'h8);
        wr(`ADCR_IDX_FLG, 16'h0008);
        @(posedge ref_clk);
        quiet <= 1'b1;
        @(posedge ref_clk);
        quiet <= 1'b0;
        repeat (6) @(posedge ref_clk);
        rc(`ADCR_IDX_FLG, 32'h0);
        rc(`ADCR_IDX_STA, 32'h0);
        wr(`ADCR_IDX_WHI, 16'h0200);
        repeat (6) @(posedge ref_clk);
        $display("test hand-over done");
        // every window mode, one value inside and one above the window
        for (int m = 0; m < 5; m++) begin
            wr(`ADCR_IDX_CTL, {9'h000, m[2:0], 4'h0});
            for (int k = 0; k < 2; k++) begin
                xfer(1'b0, `ADCR_IDX_RES, 16'h0000);
                conv(k ? 16'h0300 : 16'h0150);
                xfer(1'b0, `ADCR_IDX_FLG, 16'h0000);
                chk(r & 32'h7, {k ? hit1[m] : hit0[m], 2'h1});
                chk(win_seen, k ? hit1[m] : hit0[m]);
            end
        end
        rc(`ADCR_IDX_RES, 32'h300);
        xfer(1'b0, `ADCR_IDX_FLG, 16'h0000);
        chk(r & 32'h7, 32'h0);
        $display("test window done");
        wp <= 1'b1;
        wr(`ADCR_IDX_WLO, 16'h0055);
        wr(`ADCR_IDX_IES, 16'h000F);
        wp <= 1'b0;
        rc(`ADCR_IDX_WLO, 32'h100);
        rc(`ADCR_IDX_IES, 32'h0);
        $display("test protection done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
